// File: core/l1_caches.v
// Purpose: level-one instruction and data caches with lockable lines
// Assumes: core holds each request and its address stable until its ack
// Notes: 4-way, 16-byte lines, one miss in flight, store misses go around
// How it works
// - I-cache stores 16 KB of instructions
// - Virtual index; translation runs beside lookup
// - Tag: 22-bit physical address, valid, lock
// - I-cache LRU kept in separate array
// - Line fill buffer gathers refill words first
// - Fetch served from buffer or bus data
// - Each I-cache line lockable via maintenance op
// - D-cache stores 4 KB, virtual index, physical tag
// - D-cache keeps dirty and LRU bits per set
// - Store hit updates a locked line normally
// - Locked lines never picked as victim
// - Each D-cache line lockable via maintenance op
`timescale 1ns/1ps
`include "l1_caches_consts.vh"

module l1_caches (
  input wire sys_clk,
  input wire rst,
  input wire if_req,
  input wire [31:0] if_vaddr,
  input wire [31:0] if_paddr,
  output reg if_ack,
  output reg [31:0] if_rdata,
  input wire ls_req,
  input wire ls_we,
  input wire [3:0] ls_be,
  input wire [31:0] ls_vaddr,
  input wire [31:0] ls_paddr,
  input wire [31:0] ls_wdata,
  output reg ls_ack,
  output reg [31:0] ls_rdata,
  input wire cm_req,
  input wire cm_icache,
  input wire cm_lock,
  input wire [31:0] cm_vaddr,
  input wire [31:0] cm_paddr,
  output reg cm_ack,
  output reg cm_hit,
  output reg bus_req,
  output reg bus_we,
  output reg [3:0] bus_be,
  output reg [31:0] bus_addr,
  output reg [31:0] bus_wdata,
  input wire bus_ack,
  input wire [31:0] bus_rdata
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_WB = 5'h02;
  localparam [4:0] S_FILL = 5'h04;
  localparam [4:0] S_DONE = 5'h08;
  localparam [4:0] S_WRT = 5'h10;

  // Tag arrays indexed {way, set}, data arrays indexed {way, set, word}
  reg [`TAG_W-1:0] i_tag [0:`IC_SETS*`WAYS-1];
  reg [31:0] i_data [0:`IC_SETS*`WAYS*`LINE_WORDS-1];
  reg [`TAG_W-1:0] d_tag [0:`DC_SETS*`WAYS-1];
  reg [31:0] d_data [0:`DC_SETS*`WAYS*`LINE_WORDS-1];
  // Valid and lock bits per line, LRU and dirty per set
  reg [`IC_SETS*`WAYS-1:0] i_val;
  reg [`IC_SETS*`WAYS-1:0] i_lck;
  reg [7:0] i_lru [0:`IC_SETS-1];
  reg [`DC_SETS*`WAYS-1:0] d_val;
  reg [`DC_SETS*`WAYS-1:0] d_lck;
  reg [11:0] d_meta [0:`DC_SETS-1];

  reg [4:0] state_reg;
  reg [1:0] cnt_reg;
  reg [127:0] fb_line_reg;
  reg [3:0] fb_vld_reg;
  reg [`LPA_W-1:0] fb_pa_reg;
  reg fb_side_i_reg;
  reg [7:0] f_set_reg;
  reg [1:0] f_way_reg;
  reg [1:0] f_word_reg;
  reg f_alloc_reg;
  reg f_lock_reg;
  integer k;
  integer b;

  // Encode a one-hot hit vector
  function [1:0] enc;
    input [3:0] v;
    begin
      enc = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
    end
  endfunction

  // One-hot of a way number
  function [3:0] oh;
    input [1:0] w;
    begin
      oh = 4'h1 << w;
    end
  endfunction

  // Make way w youngest, age the younger ones by one
  function [7:0] touch;
    input [7:0] age;
    input [1:0] w;
    integer j;
    begin
      touch = age;
      for (j = 0; j < 4; j = j + 1)
        if (age[2*j +: 2] < age[2*w +: 2])
          touch[2*j +: 2] = age[2*j +: 2] + 2'h1;
      touch[2*w +: 2] = 2'h0;
    end
  endfunction

  // Oldest unlocked way; top bit says one was found
  function [2:0] pick;
    input [7:0] age;
    input [3:0] lk;
    integer j;
    begin
      pick = 3'h0;
      for (j = 0; j < 4; j = j + 1)
        if (!lk[j] && (!pick[2] || age[2*j +: 2] > age[2*pick[1:0] +: 2]))
          pick = {1'b1, j[1:0]};
    end
  endfunction

  // A request is ignored in the cycle its ack shows
  wire idle = (state_reg == S_IDLE);
  wire if_go = if_req & ~if_ack;
  wire ls_go = ls_req & ~ls_ack;
  wire cm_go = cm_req & ~cm_ack;
  wire cm_i = cm_go & cm_icache;
  wire cm_d = cm_go & ~cm_icache;

  // Set index from the virtual address, tag from the physical one
  wire [31:0] i_va = cm_i ? cm_vaddr : if_vaddr;
  wire [31:0] i_pa = cm_i ? cm_paddr : if_paddr;
  wire [31:0] d_va = cm_d ? cm_vaddr : ls_vaddr;
  wire [31:0] d_pa = cm_d ? cm_paddr : ls_paddr;
  wire [`IC_IDX_W-1:0] i_set = i_va[`SET_LSB +: `IC_IDX_W];
  wire [`DC_IDX_W-1:0] d_set = d_va[`SET_LSB +: `DC_IDX_W];
  wire [1:0] i_wd = i_va[`WORD_LSB +: 2];
  wire [1:0] d_wd = d_va[`WORD_LSB +: 2];
  wire [`TAG_W-1:0] i_ptag = i_pa[`TAG_LSB +: `TAG_W];
  wire [`TAG_W-1:0] d_ptag = d_pa[`TAG_LSB +: `TAG_W];

  // Per-way tag compare, valid and lock
  wire [3:0] i_hitv;
  wire [3:0] d_hitv;
  wire [3:0] i_lkv;
  wire [3:0] d_lkv;
  genvar w;
  generate
    for (w = 0; w < `WAYS; w = w + 1)
    begin : g_way
      localparam integer WI = w;
      localparam [1:0] WV = WI[1:0];
      assign i_hitv[w] = i_val[{WV, i_set}] && (i_tag[{WV, i_set}] == i_ptag);
      assign d_hitv[w] = d_val[{WV, d_set}] && (d_tag[{WV, d_set}] == d_ptag);
      assign i_lkv[w] = i_lck[{WV, i_set}];
      assign d_lkv[w] = d_lck[{WV, d_set}];
    end
  endgenerate

  wire i_hit = |i_hitv;
  wire d_hit = |d_hitv;
  wire [1:0] i_way = enc(i_hitv);
  wire [1:0] d_way = enc(d_hitv);
  wire [31:0] i_word = i_data[{i_way, i_set, i_wd}];
  wire [31:0] d_word = d_data[{d_way, d_set, d_wd}];
  wire [7:0] i_age = i_lru[i_set];
  wire [11:0] d_mt = d_meta[d_set];
  wire [2:0] i_vic = pick(i_age, i_lkv);
  wire [2:0] d_vic = pick(d_mt[7:0], d_lkv);
  wire d_vic_dirty = d_mt[`DIRTY_LSB + d_vic[1:0]] && d_val[{d_vic[1:0], d_set}];

  // Fetch against the fill buffer: stored word or word on the bus now
  wire [1:0] if_wd = if_paddr[`WORD_LSB +: 2];
  wire fb_line_hit = fb_side_i_reg && (fb_pa_reg == if_paddr[31:`SET_LSB]);
  wire fb_word_ok = fb_line_hit && fb_vld_reg[if_wd];
  wire [31:0] fb_word = fb_line_reg[{if_wd, 5'h00} +: 32];
  wire fill_ack = (state_reg == S_FILL) && bus_req && bus_ack;
  wire fb_bus_ok = fill_ack && fb_line_hit && (cnt_reg == if_wd);

  wire [`DC_IDX_W-1:0] f_dset = f_set_reg[`DC_IDX_W-1:0];
  wire fill_wr = (state_reg == S_DONE) && f_alloc_reg;
  wire d_st_wr = idle && !cm_go && ls_go && ls_we && d_hit;

  // Array writes; contents need no reset since valid bits guard them
  always @(posedge sys_clk)
  begin
    if (fill_wr && fb_side_i_reg)
    begin
      i_tag[{f_way_reg, f_set_reg}] <= fb_pa_reg[`TAG_LSB-`SET_LSB +: `TAG_W];
      // Own loop index here; the control process owns k
      for (b = 0; b < `LINE_WORDS; b = b + 1)
        i_data[{f_way_reg, f_set_reg, b[1:0]}] <= fb_line_reg[32*b +: 32];
    end
    if (fill_wr && !fb_side_i_reg)
    begin
      d_tag[{f_way_reg, f_dset}] <= fb_pa_reg[`TAG_LSB-`SET_LSB +: `TAG_W];
      for (b = 0; b < `LINE_WORDS; b = b + 1)
        d_data[{f_way_reg, f_dset, b[1:0]}] <= fb_line_reg[32*b +: 32];
    end
    // Lock bit is not consulted here: locked lines take stores
    if (d_st_wr)
      for (b = 0; b < 4; b = b + 1)
        if (ls_be[b])
          d_data[{d_way, d_set, d_wd}][8*b +: 8] <= ls_wdata[8*b +: 8];
  end

  // Set up a line refill, with a write-back first when needed
  task start_miss;
    input side_i;
    input [`LPA_W-1:0] pa;
    input [7:0] set;
    input [1:0] way;
    input [1:0] wd;
    input alloc;
    input lock;
    input wb;
    begin
      fb_side_i_reg <= side_i;
      fb_pa_reg <= pa;
      fb_vld_reg <= 4'h0;
      f_set_reg <= set;
      f_way_reg <= way;
      f_word_reg <= wd;
      f_alloc_reg <= alloc;
      f_lock_reg <= lock;
      cnt_reg <= 2'h0;
      state_reg <= wb ? S_WB : S_FILL;
    end
  endtask

  // Control: lookup, maintenance, miss sequencing and bus master
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= 2'h0;
      fb_line_reg <= 128'h0;
      fb_vld_reg <= 4'h0;
      fb_pa_reg <= {`LPA_W{1'b0}};
      fb_side_i_reg <= 1'b0;
      f_set_reg <= 8'h00;
      f_way_reg <= 2'h0;
      f_word_reg <= 2'h0;
      f_alloc_reg <= 1'b0;
      f_lock_reg <= 1'b0;
      i_val <= {`IC_SETS*`WAYS{1'b0}};
      i_lck <= {`IC_SETS*`WAYS{1'b0}};
      d_val <= {`DC_SETS*`WAYS{1'b0}};
      d_lck <= {`DC_SETS*`WAYS{1'b0}};
      for (k = 0; k < `IC_SETS; k = k + 1)
        i_lru[k] <= `LRU_RST;
      for (k = 0; k < `DC_SETS; k = k + 1)
        d_meta[k] <= {`DIRTY_RST, `LRU_RST};
      if_ack <= 1'b0;
      if_rdata <= 32'h0;
      ls_ack <= 1'b0;
      ls_rdata <= 32'h0;
      cm_ack <= 1'b0;
      cm_hit <= 1'b0;
      bus_req <= 1'b0;
      bus_we <= 1'b0;
      bus_be <= 4'h0;
      bus_addr <= 32'h0;
      bus_wdata <= 32'h0;
    end
    else
    begin
      if_ack <= 1'b0;
      ls_ack <= 1'b0;
      cm_ack <= 1'b0;
      case (state_reg)
        S_IDLE:
        // Maintenance first, then load/store, then fetch
        if (cm_go)
        begin
          if (cm_icache ? i_hit : d_hit)
          begin
            if (cm_icache)
              i_lck[{i_way, i_set}] <= cm_lock;
            else
              d_lck[{d_way, d_set}] <= cm_lock;
            cm_ack <= 1'b1;
            cm_hit <= 1'b1;
          end
          else if (cm_lock && cm_icache && i_vic[2])
            start_miss(1'b1, i_pa[31:`SET_LSB], i_set, i_vic[1:0], i_wd, 1'b1, 1'b1, 1'b0);
          else if (cm_lock && !cm_icache && d_vic[2])
            start_miss(1'b0, d_pa[31:`SET_LSB], {2'h0, d_set}, d_vic[1:0], d_wd, 1'b1, 1'b1,
                       d_vic_dirty);
          else
          begin
            // Unlock of an absent line, or no unlocked way to lock into
            cm_ack <= 1'b1;
            cm_hit <= 1'b0;
          end
        end
        else if (ls_go)
        begin
          if (d_hit)
          begin
            ls_ack <= 1'b1;
            ls_rdata <= d_word;
            d_meta[d_set] <= {d_mt[11:8] | (ls_we ? oh(d_way) : 4'h0),
                              touch(d_mt[7:0], d_way)};
          end
          else if (ls_we)
            state_reg <= S_WRT;
          else
            start_miss(1'b0, d_pa[31:`SET_LSB], {2'h0, d_set}, d_vic[1:0], d_wd, d_vic[2], 1'b0,
                       d_vic[2] & d_vic_dirty);
        end
        else if (if_go)
        begin
          if (i_hit)
          begin
            if_ack <= 1'b1;
            if_rdata <= i_word;
            i_lru[i_set] <= touch(i_age, i_way);
          end
          else if (fb_word_ok)
          begin
            if_ack <= 1'b1;
            if_rdata <= fb_word;
          end
          else
            start_miss(1'b1, i_pa[31:`SET_LSB], i_set, i_vic[1:0], i_wd, i_vic[2], 1'b0, 1'b0);
        end
        S_WB, S_FILL:
        begin
          // Fetch bypass while the line is still arriving
          if (state_reg == S_FILL && if_go && fb_word_ok)
          begin
            if_ack <= 1'b1;
            if_rdata <= fb_word;
          end
          else if (if_go && fb_bus_ok)
          begin
            if_ack <= 1'b1;
            if_rdata <= bus_rdata;
          end
          // One word per handshake, request drops for a cycle between
          if (!bus_req)
          begin
            bus_req <= 1'b1;
            bus_we <= (state_reg == S_WB);
            bus_be <= 4'hf;
            bus_addr <= (state_reg == S_WB) ?
                        {d_tag[{f_way_reg, f_dset}], f_dset, cnt_reg, 2'h0} :
                        {fb_pa_reg, cnt_reg, 2'h0};
            bus_wdata <= d_data[{f_way_reg, f_dset, cnt_reg}];
          end
          else if (bus_ack)
          begin
            bus_req <= 1'b0;
            cnt_reg <= cnt_reg + 2'h1;
            if (state_reg == S_FILL)
            begin
              fb_line_reg[{cnt_reg, 5'h00} +: 32] <= bus_rdata;
              fb_vld_reg[cnt_reg] <= 1'b1;
            end
            if (cnt_reg == `LAST_WORD)
              state_reg <= (state_reg == S_WB) ? S_FILL : S_DONE;
          end
        end
        S_DONE:
        begin
          // Buffered line moves into the array when allocated, new line is clean
          if (f_alloc_reg && fb_side_i_reg)
          begin
            i_val[{f_way_reg, f_set_reg}] <= 1'b1;
            i_lck[{f_way_reg, f_set_reg}] <= f_lock_reg;
            i_lru[f_set_reg] <= touch(i_lru[f_set_reg], f_way_reg);
          end
          if (f_alloc_reg && !fb_side_i_reg)
          begin
            d_val[{f_way_reg, f_dset}] <= 1'b1;
            d_lck[{f_way_reg, f_dset}] <= f_lock_reg;
            d_meta[f_dset] <= {d_meta[f_dset][11:8] & ~oh(f_way_reg),
                               touch(d_meta[f_dset][7:0], f_way_reg)};
          end
          if (f_lock_reg)
          begin
            cm_ack <= 1'b1;
            cm_hit <= 1'b1;
          end
          else if (!fb_side_i_reg)
          begin
            ls_ack <= 1'b1;
            ls_rdata <= fb_line_reg[{f_word_reg, 5'h00} +: 32];
          end
          state_reg <= S_IDLE;
        end
        S_WRT:
        // Store miss: one word straight to the bus, no allocation
        if (!bus_req)
        begin
          bus_req <= 1'b1;
          bus_we <= 1'b1;
          bus_be <= ls_be;
          bus_addr <= {ls_paddr[31:`WORD_LSB], 2'h0};
          bus_wdata <= ls_wdata;
        end
        else if (bus_ack)
        begin
          bus_req <= 1'b0;
          ls_ack <= 1'b1;
          state_reg <= S_IDLE;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

// File: core/l1_caches_consts.vh
// Purpose: shared constants of the level-one cache pair
// Assumes: 32-bit addresses, 32-bit words, 16-byte lines
// Notes: definitions only
`ifndef L1_CACHES_CONSTS_VH
`define L1_CACHES_CONSTS_VH

// Capacities in bytes
`define IC_BYTES 16384
`define DC_BYTES 4096

// Organisation: 4 ways, 4 words a line
`define WAYS 4
`define LINE_WORDS 4
`define LAST_WORD 2'h3
`define IC_SETS 256
`define IC_IDX_W 8
`define DC_SETS 64
`define DC_IDX_W 6

// Address field positions
`define WORD_LSB 2
`define SET_LSB 4
`define TAG_LSB 10
`define TAG_W 22
`define LPA_W 28

// Per-set meta layout: dirty bits above the 2-bit LRU ages
`define DIRTY_LSB 8

// Reset values: ages 3,2,1,0 for ways 3..0, all lines clean
`define LRU_RST 8'he4
`define DIRTY_RST 4'h0

`endif

// File: verif/l1_caches_assertions.sv
// Purpose: port checks for the level-one cache pair
// Assumes: core holds requests until acked
// Notes: bound to every l1_caches instance
`timescale 1ns/1ps
module l1_caches_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic if_req,
  input wire logic if_ack,
  input wire logic ls_req,
  input wire logic ls_we,
  input wire logic [3:0] ls_be,
  input wire logic ls_ack,
  input wire logic cm_req,
  input wire logic cm_ack,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [3:0] bus_be,
  input wire logic [31:0] bus_addr,
  input wire logic bus_ack
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Each answer is a lone pulse to a held request
  property p_if_src;
    if_ack |-> $past(if_req) ##1 !if_ack;
  endproperty
  a_if_src: assert property (p_if_src) else $error("stray fetch ack");
  property p_ls_src;
    ls_ack |-> $past(ls_req) ##1 !ls_ack;
  endproperty
  a_ls_src: assert property (p_ls_src) else $error("stray data ack");
  property p_cm_src;
    cm_ack |-> $past(cm_req) ##1 !cm_ack;
  endproperty
  a_cm_src: assert property (p_cm_src) else $error("stray maint ack");

  // Bus words held until acked, dropped right after
  property p_bus_hold;
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus word moved");
  property p_bus_drop;
    bus_req && bus_ack |=> !bus_req;
  endproperty
  a_bus_drop: assert property (p_bus_drop) else $error("bus req held");
  property p_bus_align;
    bus_req |-> bus_addr[1:0] == 2'h0;
  endproperty
  a_bus_align: assert property (p_bus_align) else $error("bus addr unaligned");

  // Refill walks the line upward, word after word
  property p_refill_next;
    bus_req && bus_ack && !bus_we && bus_addr[3:2] != 2'h3 |->
      ##2 bus_req && !bus_we && bus_addr == $past(bus_addr, 2) + 32'h4;
  endproperty
  a_refill_next: assert property (p_refill_next) else $error("refill order");
  property p_bus_cause;
    $rose(bus_req) && !bus_we && bus_addr[3:2] == 2'h0 |-> if_req || ls_req || cm_req;
  endproperty
  a_bus_cause: assert property (p_bus_cause) else $error("refill uncaused");

  // Store misses pass lanes; write-backs carry full words
  property p_store_be;
    $rose(bus_req) && bus_we && bus_be != 4'hf |-> ls_req && ls_we && bus_be == ls_be;
  endproperty
  a_store_be: assert property (p_store_be) else $error("store lanes");
  property p_wb_be;
    bus_req && bus_we && !(ls_req && ls_we) |-> bus_be == 4'hf;
  endproperty
  a_wb_be: assert property (p_wb_be) else $error("write-back lanes");

  c_wb: cover property (bus_req && bus_we && bus_ack && !ls_we);
  c_store_miss: cover property (bus_req && bus_we && ls_we);
  c_cm: cover property (cm_ack);
endmodule

bind l1_caches l1_caches_assertions i_l1_caches_assertions (
  .sys_clk, .rst, .if_req, .if_ack, .ls_req, .ls_we, .ls_be, .ls_ack,
  .cm_req, .cm_ack, .bus_req, .bus_we, .bus_be, .bus_addr, .bus_ack
);

// File: verif/bus_memory_model.sv
// Purpose: system bus memory behind the caches
// Assumes: one word transfer at a time
// Notes: slow adds random wait cycles
`timescale 1ns/1ps
module bus_memory_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [3:0] bus_be,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic bus_ack,
  output logic [31:0] bus_rdata
);
  logic [31:0] mem [int];
  logic [31:0] w;
  int k;

  // Untouched words read as a pattern of their address
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : {a[15:0] ^ 16'h5a3c, a[31:16]};
  endfunction

  // One word per request; data lines inverted once released
  initial
  begin
    bus_ack = 1'b0;
    bus_rdata = 32'h0;
    forever
    begin
      @(posedge sys_clk);
      if (bus_req && !rst)
      begin
        if (slow)
          repeat ($urandom_range(4)) @(posedge sys_clk);
        w = rd(bus_addr);
        for (k = 0; k < 4; k++)
          if (bus_we && bus_be[k])
            w[8*k +: 8] = bus_wdata[8*k +: 8];
        mem[bus_addr] = w;
        bus_rdata <= w;
        bus_ack <= 1'b1;
        @(posedge sys_clk);
        bus_ack <= 1'b0;
        bus_rdata <= ~w;
      end
    end
  end
endmodule

// File: verif/l1_caches_test.sv
// Purpose: self-checking bench for the cache pair
// Assumes: bus memory model on the far side
// Notes: random virtual tops, random bus stalls
`timescale 1ns/1ps
module l1_caches_test;
  logic sys_clk, rst, slow, if_req, ls_req, ls_we, cm_req, cm_icache, cm_lock;
  logic [3:0] ls_be, bus_be;
  logic [31:0] if_vaddr, if_paddr, ls_vaddr, ls_paddr, ls_wdata, cm_vaddr, cm_paddr;
  logic if_ack, ls_ack, cm_ack, cm_hit, bus_req, bus_we, bus_ack;
  logic [31:0] if_rdata, ls_rdata, bus_addr, bus_wdata, bus_rdata, b, s;
  logic [31:0] ref_mem [int];
  int errors, n_tests, lat, p, i, c;

  l1_caches i_l1_caches (
    .sys_clk, .rst, .if_req, .if_vaddr, .if_paddr, .if_ack, .if_rdata,
    .ls_req, .ls_we, .ls_be, .ls_vaddr, .ls_paddr, .ls_wdata, .ls_ack, .ls_rdata,
    .cm_req, .cm_icache, .cm_lock, .cm_vaddr, .cm_paddr, .cm_ack, .cm_hit,
    .bus_req, .bus_we, .bus_be, .bus_addr, .bus_wdata, .bus_ack, .bus_rdata
  );
  bus_memory_model i_bus_memory_model (
    .sys_clk, .rst, .slow, .bus_req, .bus_we, .bus_be, .bus_addr, .bus_wdata,
    .bus_ack, .bus_rdata
  );

  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Reference memory, independent of the far-side model
  function automatic logic [31:0] ref_rd(input logic [31:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : {a[15:0] ^ 16'h5a3c, a[31:16]};
  endfunction

  task automatic chk_data(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(string what, logic exp, logic got);
    chk_data(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // k: 0 fetch, 1 load, 2 store, 3/4 D lock/unlock, 5/6 I lock/unlock
  task automatic op(input int k, input logic [31:0] pa, output int lat);
    logic [31:0] m;
    int q;
    q = 0;
    while (q < 2)
    begin
      @(negedge sys_clk);
      q = bus_req ? 0 : q + 1;
    end
    slow = $urandom_range(1);
    m = $urandom;
    m[11:0] = pa[11:0];
    {if_vaddr, ls_vaddr, cm_vaddr} = {m, m, m};
    {if_paddr, ls_paddr, cm_paddr} = {pa, pa, pa};
    ls_we = (k == 2);
    ls_be = $urandom_range(15, 1);
    ls_wdata = $urandom;
    cm_icache = (k > 4);
    cm_lock = (k == 3 || k == 5);
    if_req = (k == 0);
    ls_req = (k == 1 || k == 2);
    cm_req = (k > 2);
    lat = 0;
    do
    begin
      @(negedge sys_clk);
      lat++;
    end
    while (!(if_ack | ls_ack | cm_ack) && lat < 300);
    // A request left unanswered ends the run
    chk_flag("ack", 1'b1, if_ack | ls_ack | cm_ack);
    if (!(if_ack | ls_ack | cm_ack))
      print_verdict;
    {if_req, ls_req, cm_req} = 3'h0;
    m = ref_rd(pa);
    if (k == 0)
      chk_data("if_rdata", m, if_rdata);
    if (k == 1)
      chk_data("ls_rdata", m, ls_rdata);
    for (int j = 0; j < 4; j++)
      if (k == 2 && ls_be[j])
        m[8*j +: 8] = ls_wdata[8*j +: 8];
    ref_mem[pa] = m;
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    {if_req, ls_req, cm_req, ls_we, cm_icache, cm_lock, slow} = 7'h0;
    {if_vaddr, if_paddr, ls_vaddr, ls_paddr, ls_wdata, cm_vaddr, cm_paddr} = 224'h0;
    ls_be = 4'h0;
    void'($urandom(4));
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk_data("idle", 32'h0, {26'h0, if_ack, ls_ack, cm_ack, cm_hit, bus_req, bus_we});
    // Fill all of the I-cache, then every line must hit
    for (p = 0; p < 2; p++)
      for (i = 0; i < 1024; i++)
      begin
        op(0, 32'h0010_0000 + i * 16 + $urandom_range(3) * 4, lat);
        if (p == 1)
          chk_flag("if_hit", 1'b1, lat == 1);
      end
    // D-cache: fill, dirty by stores, evict, read back
    for (p = 0; p < 4; p++)
      for (i = 0; i < 256; i++)
      begin
        b = 32'h0020_0000 + (p == 2) * 32'h1000 + i * 16 + $urandom_range(3) * 4;
        op(p == 1 ? 2 : 1, b, lat);
        if (p == 1)
          chk_flag("ls_hit", 1'b1, lat == 1);
      end
    // Store miss goes around the cache
    op(2, 32'h0030_0010, lat);
    op(1, 32'h0030_0010, lat);
    // Locking in both caches; locked lines survive conflicts
    for (c = 0; c < 2; c++)
    begin
      b = c ? 32'h0050_0000 : 32'h0040_0000;
      s = c ? 32'h1000 : 32'h400;
      op(3 + 2 * c, b, lat);
      chk_flag("cm_hit", 1'b1, cm_hit);
      op(2 - 2 * c, b, lat);
      chk_flag("lock_hit", 1'b1, lat == 1);
      for (i = 1; i < 9; i++)
        op(1 - c, b + i * s, lat);
      op(1 - c, b, lat);
      chk_flag("lock_keep", 1'b1, lat == 1);
      for (i = 1; i < 5; i++)
      begin
        op(3 + 2 * c, b + i * s, lat);
        chk_flag("cm_hit", i < 4, cm_hit);
      end
      // Set fully locked: no allocation, I side then answers from the buffer
      op(1 - c, b + 4 * s, lat);
      op(1 - c, b + 4 * s + 4, lat);
      chk_flag("fb_hit", c == 1, lat == 1);
      op(4 + 2 * c, b, lat);
      chk_flag("cm_hit", 1'b1, cm_hit);
      op(4 + 2 * c, b + 5 * s, lat);
      chk_flag("cm_hit", 1'b0, cm_hit);
      // Lock of a present line takes one cycle
      op(3 + 2 * c, b, lat);
      chk_flag("relock", 1'b1, lat == 1 && cm_hit);
    end
    print_verdict;
  end

  // Hang guard, well past the expected run length
  initial
  begin
    repeat (95000) @(posedge sys_clk);
    errors++;
    print_verdict;
  end
endmodule
